// >>> lfc_coil_ctrl.sv
// lens-focus coil driver control: command decode, parameters, stepped target
// ==========================================
// Function
// - power-save bit: 0 puts the driver in standby, 1 runs it
// - enable bit: 0 leaves coil output off, 1 sinks regulated current unless in standby
// - mode bit: 0 disables current-source drive mode, 1 enables it outside standby
// - select 000 routes data to target, 001 to 100 to parameter sets
// - target selected: all ten data bits become the target position code
// - set one holds resonance in bits 7:3, slew rate in bits 1:0
// - set two stores ten data bits as first idle coil current
// - set three stores ten data bits as second idle coil current
// - set four bits 7:5 give step size, smallest is one code
// - set four bits 4:0 give step interval in 50 us units
`include "lfc_consts.svh"
module lfc_coil_ctrl #(
	parameter int UNIT_CYC = `LFC_UNIT_CYC,
	parameter logic [6:0] DEV_ADDR = `LFC_DEV_ADDR
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	output logic                      standby,
	output logic                      coil_sink_en,
	output logic                      current_source_drive,
	output logic [9:0]                dac_code,
	output lfc_pkg::lfc_params_t      params,
	output logic                      moving
);
	import lfc_pkg::*;

	lfc_cmd_t    cmd;
	logic        cmd_valid;
	logic [15:0] cmd_word;
	logic        ack_oe;
	logic        ps_q;
	logic        en_q;
	logic        mode_q;
	lfc_params_t par_q;
	logic [9:0]  code_q;
	logic [13:0] unit_cnt_q;
	logic [4:0]  tick_cnt_q;
	logic        wr_target;
	logic        wr_res_slew;
	logic        wr_idle1;
	logic        wr_idle2;
	logic        wr_step;
	logic        unit_end;
	logic        step_due;

	assign cmd = lfc_cmd_t'(cmd_word);
	// a step falls on the last unit of each interval
	assign unit_end = (unit_cnt_q == 14'(UNIT_CYC - 1));
	assign step_due = unit_end && (tick_cnt_q >= par_q.step_time - 5'h01);

	// step magnitude in codes: field value plus one, so zero still moves
	function automatic logic [9:0] step_codes(input logic [2:0] sz);
		step_codes = {7'h00, sz} + 10'h001;
	endfunction

	function automatic logic [9:0] approach(input logic [9:0] cur,
	                                        input logic [9:0] tgt,
	                                        input logic [9:0] stp);
		logic [9:0] diff;
		diff = (tgt > cur) ? (tgt - cur) : (cur - tgt);
		if (diff <= stp) begin
			approach = tgt;
		end else if (tgt > cur) begin
			approach = cur + stp;
		end else begin
			approach = cur - stp;
		end
	endfunction

	// ==========================================
	// serial receiver
	lfc_twi_rx #(
		.DEV_ADDR (DEV_ADDR)
	) u_rx (
		.core_clk  (core_clk),
		.rst       (rst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_oe    (ack_oe),
		.cmd_valid (cmd_valid),
		.cmd_word  (cmd_word)
	);

	// ==========================================
	// select decode; codes 5 to 7 write nothing
	always_comb begin
		wr_target   = 1'b0;
		wr_res_slew = 1'b0;
		wr_idle1    = 1'b0;
		wr_idle2    = 1'b0;
		wr_step     = 1'b0;
		if (!cmd_valid) begin
			wr_target = 1'b0;
		end else if (cmd.register_select_code == `LFC_SEL_TARGET) begin
			wr_target = 1'b1;
		end else if (cmd.register_select_code == `LFC_SEL_RES_SLEW) begin
			wr_res_slew = 1'b1;
		end else if (cmd.register_select_code == `LFC_SEL_IDLE1) begin
			wr_idle1 = 1'b1;
		end else if (cmd.register_select_code == `LFC_SEL_IDLE2) begin
			wr_idle2 = 1'b1;
		end else if (cmd.register_select_code == `LFC_SEL_STEP) begin
			wr_step = 1'b1;
		end
	end

	// ==========================================
	// control bits, latched from every command
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ps_q   <= 1'b0;
			en_q   <= 1'b0;
			mode_q <= 1'b0;
		end else if (cmd_valid) begin
			ps_q   <= cmd.power_save_n;
			en_q   <= cmd.out_enable;
			mode_q <= cmd.current_source_drive;
		end
	end

	// ==========================================
	// parameter registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			par_q <= '0;
		end else if (wr_target) begin
			par_q.target_current_limit <= cmd.payload_bits;
		end else if (wr_res_slew) begin
			par_q.resonance <= cmd.payload_bits[`LFC_RES_HI:`LFC_RES_LO];
			par_q.slew      <= cmd.payload_bits[`LFC_SLEW_HI:`LFC_SLEW_LO];
		end else if (wr_idle1) begin
			par_q.idle_current_first <= cmd.payload_bits;
		end else if (wr_idle2) begin
			par_q.idle_current_second <= cmd.payload_bits;
		end else if (wr_step) begin
			par_q.step_size <= cmd.payload_bits[`LFC_SSIZE_HI:`LFC_SSIZE_LO];
			par_q.step_time <= cmd.payload_bits[`LFC_STIME_HI:`LFC_STIME_LO];
		end
	end

	// ==========================================
	// step interval timer; held in reset during standby
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			unit_cnt_q <= 14'h0000;
			tick_cnt_q <= 5'h00;
		end else if (!ps_q || code_q == par_q.target_current_limit) begin
			unit_cnt_q <= 14'h0000;
			tick_cnt_q <= 5'h00;
		end else if (unit_end) begin
			unit_cnt_q <= 14'h0000;
			// wrap on the stepping unit so steps land step_time units apart
			tick_cnt_q <= step_due ? 5'h00 : tick_cnt_q + 5'h01;
		end else begin
			unit_cnt_q <= unit_cnt_q + 14'h0001;
		end
	end

	// ==========================================
	// output code ramp
	// step time zero means jump at once: no interval is defined
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			code_q <= `LFC_RESET_CODE;
		end else if (!ps_q) begin
			code_q <= code_q;
		end else if (par_q.step_time == 5'h00) begin
			code_q <= par_q.target_current_limit;
		end else if (step_due) begin
			code_q <= approach(code_q, par_q.target_current_limit,
			                   step_codes(par_q.step_size));
		end
	end

	// ==========================================
	// bus outputs; open drain, so only low is ever driven
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			sda_oe  <= ack_oe;
		end
	end

	// ==========================================
	// status outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			standby              <= 1'b1;
			coil_sink_en         <= 1'b0;
			current_source_drive <= 1'b0;
			moving               <= 1'b0;
		end else begin
			standby              <= ~ps_q;
			coil_sink_en         <= ps_q & en_q;
			current_source_drive <= ps_q & mode_q;
			moving               <= ps_q && (code_q != par_q.target_current_limit);
		end
	end

	// ==========================================
	// converter code output
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dac_code <= `LFC_RESET_CODE;
		end else begin
			dac_code <= code_q;
		end
	end

	// ==========================================
	// parameter outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			params <= '0;
		end else begin
			params <= par_q;
		end
	end
endmodule

// >>> lfc_consts.svh
// constants for the lens-focus coil driver control block
`ifndef LFC_CONSTS_SVH
`define LFC_CONSTS_SVH
// ==========================================
// command word field positions
`define LFC_CMD_W         16
`define LFC_PS_BIT        15
`define LFC_EN_BIT        14
`define LFC_MODE_BIT      13
`define LFC_SEL_HI        12
`define LFC_SEL_LO        10
`define LFC_DATA_HI       9
`define LFC_DATA_LO       0
// ==========================================
// register select codes
`define LFC_SEL_TARGET    3'h0
`define LFC_SEL_RES_SLEW  3'h1
`define LFC_SEL_IDLE1     3'h2
`define LFC_SEL_IDLE2     3'h3
`define LFC_SEL_STEP      3'h4
// ==========================================
// parameter set field positions
`define LFC_RES_HI        7
`define LFC_RES_LO        3
`define LFC_SLEW_HI       1
`define LFC_SLEW_LO       0
`define LFC_SSIZE_HI      7
`define LFC_SSIZE_LO      5
`define LFC_STIME_HI      4
`define LFC_STIME_LO      0
// ==========================================
// timing
`define LFC_CLK_MHZ       250
`define LFC_STEP_UNIT_US  50
`define LFC_UNIT_CYC      (`LFC_STEP_UNIT_US * `LFC_CLK_MHZ)
// ==========================================
// two-wire bus address and converter reset code
`define LFC_DEV_ADDR      7'h0c
`define LFC_RESET_CODE    10'h000
`endif

// >>> lfc_pkg.sv
// types shared by the lens-focus coil driver control block
package lfc_pkg;
	typedef struct packed {
		logic       power_save_n;
		logic       out_enable;
		logic       current_source_drive;
		logic [2:0] register_select_code;
		logic [9:0] payload_bits;
	} lfc_cmd_t;

	typedef struct packed {
		logic [9:0] target_current_limit;
		logic [4:0] resonance;
		logic [1:0] slew;
		logic [9:0] idle_current_first;
		logic [9:0] idle_current_second;
		logic [2:0] step_size;
		logic [4:0] step_time;
	} lfc_params_t;
endpackage

// >>> lfc_twi_rx.sv
// two-wire bus write receiver: collects a two-byte command word
`include "lfc_consts.svh"
module lfc_twi_rx #(
	parameter logic [6:0] DEV_ADDR = `LFC_DEV_ADDR
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output logic                        sda_oe,
	output logic                        cmd_valid,
	output logic [`LFC_CMD_W-1:0]       cmd_word
);
	import lfc_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_DATA, ST_SKIP} lfc_rx_st_t;

	lfc_rx_st_t  st_q;
	logic        scl_q;
	logic        sda_q;
	logic [3:0]  bit_cnt_q;
	logic [7:0]  shift_q;
	logic [1:0]  byte_cnt_q;
	logic [7:0]  word_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;

	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;

	// ==========================================
	// line history; inputs are synchronous to core_clk
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// ==========================================
	// byte receiver and ack
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q       <= ST_IDLE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			byte_cnt_q <= 2'h0;
			word_q     <= 8'h00;
			sda_oe     <= 1'b0;
			cmd_valid  <= 1'b0;
			cmd_word   <= 16'h0000;
		end else begin
			cmd_valid <= 1'b0;
			if (start_c) begin
				st_q       <= ST_ADDR;
				bit_cnt_q  <= 4'h0;
				byte_cnt_q <= 2'h0;
				sda_oe     <= 1'b0;
			end else if (stop_c) begin
				st_q   <= ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st_q)
					ST_ADDR, ST_DATA: begin
						if (scl_rise) begin
							shift_q   <= {shift_q[6:0], sda_in};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
						if (scl_fall && bit_cnt_q == 4'h8) begin
							bit_cnt_q <= 4'h0;
							if (st_q == ST_ADDR) begin
								// only writes to our address are acked
								sda_oe    <= (shift_q == {DEV_ADDR, 1'b0});
								st_q      <= (shift_q == {DEV_ADDR, 1'b0}) ? ST_ACK : ST_SKIP;
							end else begin
								sda_oe <= 1'b1;
								st_q   <= ST_ACK;
								if (byte_cnt_q == 2'h0) begin
									word_q     <= shift_q;
									byte_cnt_q <= 2'h1;
								end else begin
									// second byte completes the command
									cmd_word   <= {word_q, shift_q};
									cmd_valid  <= 1'b1;
									byte_cnt_q <= 2'h0;
								end
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							st_q   <= ST_DATA;
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule

// >>> lfc_coil_ctrl_chk.sv
// port assertions for the coil driver control block
module lfc_coil_ctrl_chk (
	input wire logic                 core_clk,
	input wire logic                 rst,
	input wire logic                 scl_in,
	input wire logic                 sda_oe,
	input wire logic                 standby,
	input wire logic                 coil_sink_en,
	input wire logic                 current_source_drive,
	input wire logic [9:0]           dac_code,
	input wire lfc_pkg::lfc_params_t params,
	input wire logic                 moving
);
	import lfc_pkg::*;
	// ==========
	// properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_freeze; standby && $past(standby) |-> $stable(dac_code); endproperty
	a_freeze: assert property (p_freeze) else $error("code moved in standby");
	property p_still; standby |-> !moving; endproperty
	a_still: assert property (p_still) else $error("moving in standby");
	property p_sink; coil_sink_en |-> !standby; endproperty
	a_sink: assert property (p_sink) else $error("sink while standby");
	property p_drive; current_source_drive |-> !standby; endproperty
	a_drive: assert property (p_drive) else $error("drive while standby");
	property p_step;
		$changed(dac_code) && $past(params.step_time) != 5'h0 |->
		((dac_code > $past(dac_code)) ? dac_code - $past(dac_code) : $past(dac_code) - dac_code)
		<= {7'h0, $past(params.step_size)} + 10'h1;
	endproperty
	a_step: assert property (p_step) else $error("step too large");
	// sim unit is at least four cycles, so three quiet cycles always hold
	property p_gap;
		$changed(dac_code) && moving && params.step_time != 5'h0 |=> $stable(dac_code)[*3];
	endproperty
	a_gap: assert property (p_gap) else $error("steps too close");
	property p_settle;
		(!moving && !standby && $stable(params.target_current_limit))[*3] |->
		dac_code == params.target_current_limit;
	endproperty
	a_settle: assert property (p_settle) else $error("idle off target");
	property p_ack; $changed(sda_oe) |-> !scl_in && !$past(scl_in); endproperty
	a_ack: assert property (p_ack) else $error("ack moved while bus clock high");
endmodule
bind lfc_coil_ctrl lfc_coil_ctrl_chk chk (.core_clk(core_clk), .rst(rst), .scl_in(scl_in),
	.sda_oe(sda_oe), .standby(standby), .coil_sink_en(coil_sink_en),
	.current_source_drive(current_source_drive), .dac_code(dac_code),
	.params(params), .moving(moving));

// >>> lfc_host_bfm.sv
// two-wire bus host model that writes command words
module lfc_host_bfm (
	input  wire logic core_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 6;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// data moves one cycle after the clock falls, never while it is high
	task automatic clk_bit(input logic b, output logic seen);
		tick(1);
		sda_drv = b;
		tick(HALF);
		scl = 1'b1;
		tick(HALF / 2);
		seen = sda_line;
		tick(HALF - HALF / 2);
		scl = 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic write_cmd(input logic [7:0] adr, input logic [15:0] w, output logic [2:0] ack);
		sda_drv = 1'b0;
		tick(HALF);
		scl = 1'b0;
		put_byte(adr, ack[2]);
		put_byte(w[15:8], ack[1]);
		put_byte(w[7:0], ack[0]);
		tick(1);
		sda_drv = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_drv = 1'b1;
		tick(HALF);
	endtask
endmodule

// >>> tb.sv
// self-checking bench for the coil driver control block
`include "lfc_consts.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
	$display("mismatch %s exp %0h got %0h", nm, e, s); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lfc_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        scl, sda_drv, sda_out, sda_oe, standby, sink, csd, moving;
	logic [9:0]  dac_code;
	logic [2:0]  ack;
	int          w;
	logic [9:0]  dac_seen;
	int          run_len = 0;
	int          last_gap = 0;
	lfc_params_t params;
	localparam int UNIT = 4;
	// pull-up: the line is low only where a side drives it low
	wire         sda_line = sda_drv & (~sda_oe | sda_out);
	int errors = 0, check_count = 0, seed = 8348;
	int m[10];
	int q[$];
	always #2 core_clk = ~core_clk;
	// cycles between code changes, looked at mid-cycle where outputs are settled
	always @(negedge core_clk) begin
		if (dac_code !== dac_seen) begin
			last_gap = run_len + 1;
			run_len = 0;
		end else begin
			run_len++;
		end
		dac_seen = dac_code;
	end
	lfc_host_bfm host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	lfc_coil_ctrl #(.UNIT_CYC(UNIT)) uut (.core_clk(core_clk), .rst(rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .standby(standby),
		.coil_sink_en(sink), .current_source_drive(csd), .dac_code(dac_code),
		.params(params), .moving(moving));
	// ==========
	// model: m = ps en mode target res slew idle1 idle2 size time
	task automatic check_all();
		`CHK("standby", m[0] == 0, standby)
		`CHK("sink", m[0] && m[1], sink)
		`CHK("drive", m[0] && m[2], csd)
		`CHK("target", m[3], params.target_current_limit)
		`CHK("res", m[4], params.resonance)
		`CHK("slew", m[5], params.slew)
		`CHK("idle1", m[6], params.idle_current_first)
		`CHK("idle2", m[7], params.idle_current_second)
		`CHK("size", m[8], params.step_size)
		`CHK("time", m[9], params.step_time)
	endtask
	task automatic send(input logic [15:0] c);
		logic [15:0] v;
		host.write_cmd({`LFC_DEV_ADDR, 1'b0}, c, ack);
		`CHK("ack", 3'h7, ack)
		q.push_back(c);
		v = q.pop_front();
		m[0] = v[15]; m[1] = v[14]; m[2] = v[13];
		case (v[12:10])
			3'h0: m[3] = v[9:0];
			3'h1: begin m[4] = v[7:3]; m[5] = v[1:0]; end
			3'h2: m[6] = v[9:0];
			3'h3: m[7] = v[9:0];
			3'h4: begin m[8] = v[7:5]; m[9] = v[4:0]; end
			default: ;
		endcase
		repeat (4) @(posedge core_clk);
		#1;
		check_all();
	endtask
	// bounded wait so a stuck ramp cannot hang the run
	task automatic settle();
		for (int i = 0; i < 3000 && moving !== 1'b0; i++) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("dac", m[3], dac_code)
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		stop_test();
	end
	initial begin
		foreach (m[i]) m[i] = 0;
		repeat (5) @(posedge core_clk);
		#1 rst = 1'b0;
		check_all();
		for (int k = 0; k < 8; k++) begin
			w = $random(seed);
			send({k[2:0], 3'h0, w[9:0]});
			if (m[0] != 0) settle();
		end
		$display("test control bits done");
		for (int s = 1; s < 5; s++) begin
			w = $random(seed);
			send({3'h6, s[2:0], w[9:0]});
		end
		$display("test parameter sets done");
		send({3'h6, 3'h4, 10'h041});
		w = $random(seed);
		send({3'h6, 3'h0, w[9:0]});
		settle();
		w = $random(seed);
		send({3'h6, 3'h0, w[9:0]});
		send({3'h0, 3'h1, w[9:0]});
		send({3'h6, 3'h1, w[9:0]});
		settle();
		$display("test stepped ramp done");
		send({3'h6, 3'h4, 10'h003});
		send({3'h6, 3'h0, m[3][9:0] ^ 10'h002});
		settle();
		`CHK("gap", 3 * UNIT, last_gap)
		send({3'h6, 3'h5, 10'h3ff});
		$display("test step interval done");
		host.write_cmd({`LFC_DEV_ADDR ^ 7'h01, 1'b0}, 16'hc3ff, ack);
		`CHK("ack", 3'h0, ack)
		check_all();
		$display("test foreign address done");
		host.write_cmd({`LFC_DEV_ADDR, 1'b1}, 16'hc3ff, ack);
		`CHK("ack", 3'h0, ack)
		check_all();
		$display("test read bit done");
		stop_test();
	end
endmodule
